// ---- src/cct_consts.svh ----
// Register indexes, field positions, reset values and counts of the timer.
// Assumes an 8-bit register port with a 4-bit register index.
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH

// Register indexes on the register port
`define CCT_IDX_CTRL_TWO   4'h1
`define CCT_IDX_CTRL_ONE   4'h2
`define CCT_IDX_STATUS     4'h3
`define CCT_IDX_CAP_A_HI   4'h4
`define CCT_IDX_CAP_A_LO   4'h5
`define CCT_IDX_CMP_A_HI   4'h6
`define CCT_IDX_CMP_A_LO   4'h7
`define CCT_IDX_CNT_HI     4'h8
`define CCT_IDX_CNT_LO     4'h9
`define CCT_IDX_ALT_HI     4'hA
`define CCT_IDX_ALT_LO     4'hB
`define CCT_IDX_CAP_B_HI   4'hC
`define CCT_IDX_CAP_B_LO   4'hD
`define CCT_IDX_CMP_B_HI   4'hE
`define CCT_IDX_CMP_B_LO   4'hF

// Control register one fields
`define CCT_C1_CAP_IRQ_EN  7
`define CCT_C1_CMP_IRQ_EN  6
`define CCT_C1_OVF_IRQ_EN  5
`define CCT_C1_FORCE_B     4
`define CCT_C1_FORCE_A     3
`define CCT_C1_LEVEL_B     2
`define CCT_C1_CAP_EDGE_A  1
`define CCT_C1_LEVEL_A     0

// Control register two fields
`define CCT_C2_PIN_EN_A    7
`define CCT_C2_PIN_EN_B    6
`define CCT_C2_SINGLE      5
`define CCT_C2_PWIDTH      4
`define CCT_C2_CLK_HI      3
`define CCT_C2_CLK_LO      2
`define CCT_C2_CAP_EDGE_B  1
`define CCT_C2_EXT_EDGE    0

// Flag vector positions, status bit = position + 3
`define CCT_F_CAP_A        4
`define CCT_F_CMP_A        3
`define CCT_F_OVF          2
`define CCT_F_CAP_B        1
`define CCT_F_CMP_B        0

// Reset values, the single-shot capture value and the count top
`define CCT_RST_CTRL       8'h00
`define CCT_RST_COUNT      16'hFFFC
`define CCT_RST_COMPARE    16'h8000
`define CCT_SINGLE_CAPTURE 16'hFFFD
`define CCT_COUNT_TOP      16'hFFFF

`endif

// ---- src/cct_pkg.sv ----
// Types shared by the capture/compare timer.
// Assumes the constants header is compiled alongside.
package cct_pkg;
    typedef enum logic [1:0] {
        CCT_DIV4,
        CCT_DIV2,
        CCT_DIV8,
        CCT_EXT
    } cct_clock_e;
    typedef logic [4:0] cct_flags_t;
endpackage

// ---- src/cct_timer.sv ----
// Capture/compare timer: control, flags, interrupt and low-power behaviour.
// Assumes a synchronous register port and pins sampled on clock.
`timescale 1ns/100ps
`include "cct_consts.svh"

module cct_timer #(
    parameter bit HAS_EXT_CLOCK = 1'b1
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    input  wire logic       haltMode,
    input  wire logic       wakeByIrq,
    input  wire logic       cpuIrqMask,
    input  wire logic       capturePinA,
    input  wire logic       capturePinB,
    input  wire logic       extClockPin,
    output logic            comparePinA,
    output logic            comparePinAEn,
    output logic            comparePinB,
    output logic            comparePinBEn,
    output logic            timerIrq,
    output logic            waitWakeReq
);

    function automatic logic edgeHit(input logic rising, input logic cur,
                                     input logic prev);
        edgeHit = rising ? (cur & ~prev) : (~cur & prev);
    endfunction

    logic [7:0]        ctrlOne_q;
    logic [7:0]        ctrlTwo_q;
    logic [15:0]       count_q;
    logic [15:0]       capA_q;
    logic [15:0]       capB_q;
    logic [15:0]       cmpA_q;
    logic [15:0]       cmpB_q;
    logic              cmpAHold_q;
    logic              cmpBHold_q;
    cct_pkg::cct_flags_t flags_q;
    cct_pkg::cct_flags_t seen_q;
    logic [1:0]        armed_q;
    logic [2:0]        div_q;
    logic              tick_q;
    logic              pinA_q;
    logic              pinB_q;
    logic [7:0]        rdData_q;
    logic [2:0]        syncOne_q;
    logic [2:0]        syncTwo_q;
    logic [2:0]        syncOld_q;

    // Pin synchronisers, a third stage for edge detection
    wire [2:0] pinsIn = {extClockPin, capturePinB, capturePinA};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
            always_ff @(posedge clock) begin
                syncOne_q[gi] <= pinsIn[gi];
                syncTwo_q[gi] <= syncOne_q[gi];
                syncOld_q[gi] <= syncTwo_q[gi];
            end
        end
    endgenerate

    // Control fields
    wire capIrqEn  = ctrlOne_q[`CCT_C1_CAP_IRQ_EN];
    wire cmpIrqEn  = ctrlOne_q[`CCT_C1_CMP_IRQ_EN];
    wire ovfIrqEn  = ctrlOne_q[`CCT_C1_OVF_IRQ_EN];
    wire forceB    = ctrlOne_q[`CCT_C1_FORCE_B];
    wire forceA    = ctrlOne_q[`CCT_C1_FORCE_A];
    wire levelB    = ctrlOne_q[`CCT_C1_LEVEL_B];
    wire capEdgeA  = ctrlOne_q[`CCT_C1_CAP_EDGE_A];
    wire levelA    = ctrlOne_q[`CCT_C1_LEVEL_A];
    wire pinEnA    = ctrlTwo_q[`CCT_C2_PIN_EN_A];
    wire pinEnB    = ctrlTwo_q[`CCT_C2_PIN_EN_B];
    wire pwidth    = ctrlTwo_q[`CCT_C2_PWIDTH];
    wire single    = ctrlTwo_q[`CCT_C2_SINGLE] & ~pwidth;
    wire capEdgeB  = ctrlTwo_q[`CCT_C2_CAP_EDGE_B];
    wire extEdge   = ctrlTwo_q[`CCT_C2_EXT_EDGE];
    wire plainMode = ~single & ~pwidth;
    cct_pkg::cct_clock_e clkSel;
    assign clkSel = cct_pkg::cct_clock_e'(
        ctrlTwo_q[`CCT_C2_CLK_HI:`CCT_C2_CLK_LO]);

    // Register access decode
    wire wrCtrlOne = regWrite & (regAddr == `CCT_IDX_CTRL_ONE);
    wire wrCtrlTwo = regWrite & (regAddr == `CCT_IDX_CTRL_TWO);
    wire rdStatus  = regRead  & (regAddr == `CCT_IDX_STATUS);
    wire access    = regWrite | regRead;
    wire accCapALo = access & (regAddr == `CCT_IDX_CAP_A_LO);
    wire accCapBLo = access & (regAddr == `CCT_IDX_CAP_B_LO);
    wire accCmpALo = access & (regAddr == `CCT_IDX_CMP_A_LO);
    wire accCmpBLo = access & (regAddr == `CCT_IDX_CMP_B_LO);
    wire accCntLo  = access & (regAddr == `CCT_IDX_CNT_LO);
    wire wrCmpAHi  = regWrite & (regAddr == `CCT_IDX_CMP_A_HI);
    wire wrCmpALo  = regWrite & (regAddr == `CCT_IDX_CMP_A_LO);
    wire wrCmpBHi  = regWrite & (regAddr == `CCT_IDX_CMP_B_HI);
    wire wrCmpBLo  = regWrite & (regAddr == `CCT_IDX_CMP_B_LO);
    wire wrCntLo   = regWrite & ((regAddr == `CCT_IDX_CNT_LO) |
                                 (regAddr == `CCT_IDX_ALT_LO));

    // Edge events on synchronised pins
    wire extHit  = edgeHit(extEdge, syncTwo_q[2], syncOld_q[2]);
    wire edgeA   = edgeHit(capEdgeA, syncTwo_q[0], syncOld_q[0]);
    wire edgeB   = edgeHit(capEdgeB, syncTwo_q[1], syncOld_q[1]);

    // Counter clock selection; nothing counts in halt
    logic tickSel;
    always_comb begin
        case (clkSel)
            cct_pkg::CCT_DIV4: tickSel = (div_q[1:0] == 2'b11);
            cct_pkg::CCT_DIV2: tickSel = div_q[0];
            cct_pkg::CCT_DIV8: tickSel = (div_q == 3'b111);
            cct_pkg::CCT_EXT:  tickSel = HAS_EXT_CLOCK & extHit;
            default:           tickSel = 1'b0;
        endcase
    end
    wire tick = tickSel & ~haltMode;

    // Compare matches, sampled the cycle after the count moved
    wire matchA = tick_q & ~cmpAHold_q & (count_q == cmpA_q) & ~haltMode;
    wire matchB = tick_q & ~cmpBHold_q & (count_q == cmpB_q) & ~haltMode;

    // Mode events
    wire run       = ~haltMode;
    wire capNormA  = run & plainMode & edgeA;
    wire capNormB  = run & edgeB;
    wire singleHit = run & single & edgeA;
    wire periodEnd = pwidth & matchB;
    wire overflow  = tick & (count_q == `CCT_COUNT_TOP);
    wire wakeA     = wakeByIrq & armed_q[0];
    wire wakeB     = wakeByIrq & armed_q[1];
    wire cntReload = wrCntLo | singleHit | periodEnd;

    // Hardware flag sets
    cct_pkg::cct_flags_t flagSet;
    assign flagSet[`CCT_F_CAP_A] = capNormA | singleHit | wakeA
                                 | periodEnd;
    assign flagSet[`CCT_F_CMP_A] = matchA & plainMode;
    assign flagSet[`CCT_F_OVF]   = overflow;
    assign flagSet[`CCT_F_CAP_B] = capNormB | wakeB;
    assign flagSet[`CCT_F_CMP_B] = matchB & ~pwidth;

    // Low byte accesses that complete a clear
    cct_pkg::cct_flags_t flagAcc;
    assign flagAcc[`CCT_F_CAP_A] = accCapALo;
    assign flagAcc[`CCT_F_CMP_A] = accCmpALo;
    assign flagAcc[`CCT_F_OVF]   = accCntLo;
    assign flagAcc[`CCT_F_CAP_B] = accCapBLo;
    assign flagAcc[`CCT_F_CMP_B] = accCmpBLo;
    wire [4:0] flagClr = seen_q & flagAcc;

    // Control registers
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrlOne_q <= `CCT_RST_CTRL;
            ctrlTwo_q <= `CCT_RST_CTRL;
        end else begin
            if (wrCtrlOne) begin
                ctrlOne_q <= regWrData;
            end
            if (wrCtrlTwo) begin
                ctrlTwo_q <= regWrData;
            end
        end
    end

    // Prescaler and counter
    always_ff @(posedge clock) begin
        if (srst) begin
            div_q   <= 3'h0;
            tick_q  <= 1'b0;
            count_q <= `CCT_RST_COUNT;
        end else begin
            tick_q <= tick;
            if (run) begin
                div_q <= div_q + 3'h1;
            end
            if (cntReload) begin
                count_q <= `CCT_RST_COUNT;
            end else if (tick) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // Compare values; high write holds compare until low write
    always_ff @(posedge clock) begin
        if (srst) begin
            cmpA_q     <= `CCT_RST_COMPARE;
            cmpB_q     <= `CCT_RST_COMPARE;
            cmpAHold_q <= 1'b0;
            cmpBHold_q <= 1'b0;
        end else begin
            if (wrCmpAHi) begin
                cmpA_q[15:8] <= regWrData;
                cmpAHold_q   <= 1'b1;
            end
            if (wrCmpALo) begin
                cmpA_q[7:0] <= regWrData;
                cmpAHold_q  <= 1'b0;
            end
            if (wrCmpBHi) begin
                cmpB_q[15:8] <= regWrData;
                cmpBHold_q   <= 1'b1;
            end
            if (wrCmpBLo) begin
                cmpB_q[7:0] <= regWrData;
                cmpBHold_q  <= 1'b0;
            end
        end
    end

    // Capture registers and halt arming
    always_ff @(posedge clock) begin
        if (srst) begin
            capA_q  <= 16'h0000;
            capB_q  <= 16'h0000;
            armed_q <= 2'b00;
        end else begin
            if (singleHit) begin
                capA_q <= `CCT_SINGLE_CAPTURE;
            end else if (capNormA | wakeA) begin
                capA_q <= count_q;
            end
            if (capNormB | wakeB) begin
                capB_q <= count_q;
            end
            if (wakeByIrq) begin
                armed_q <= 2'b00;
            end else if (haltMode) begin
                armed_q[0] <= armed_q[0] | (edgeA & plainMode);
                armed_q[1] <= armed_q[1] | edgeB;
            end
        end
    end

    // Status flags: a set in the clearing cycle wins
    always_ff @(posedge clock) begin
        if (srst) begin
            flags_q <= 5'b00000;
            seen_q  <= 5'b00000;
        end else begin
            flags_q <= (flags_q & ~flagClr) | flagSet;
            if (rdStatus) begin
                seen_q <= flags_q;
            end else begin
                seen_q <= seen_q & ~flagAcc;
            end
        end
    end

    // Output levels on the compare pins
    always_ff @(posedge clock) begin
        if (srst) begin
            pinA_q <= 1'b0;
            pinB_q <= 1'b0;
        end else begin
            if (pwidth) begin
                if (periodEnd) begin
                    pinA_q <= levelB;
                end else if (matchA) begin
                    pinA_q <= levelA;
                end
            end else if (single) begin
                if (singleHit) begin
                    pinA_q <= levelB;
                end else if (matchA) begin
                    pinA_q <= levelA;
                end
            end else if (forceA) begin
                pinA_q <= levelA;
            end else if (matchA) begin
                pinA_q <= levelA;
            end
            if (plainMode & (forceB | matchB)) begin
                pinB_q <= levelB;
            end
        end
    end

    assign comparePinA   = pinA_q;
    assign comparePinB   = pinB_q;
    assign comparePinAEn = pinEnA;
    assign comparePinBEn = pinEnB;

    // Shared interrupt request
    wire anyEnabled = (capIrqEn & (flags_q[`CCT_F_CAP_A] |
                                   flags_q[`CCT_F_CAP_B]))
                    | (cmpIrqEn & (flags_q[`CCT_F_CMP_A] |
                                   flags_q[`CCT_F_CMP_B]))
                    | (ovfIrqEn & flags_q[`CCT_F_OVF]);
    assign timerIrq    = anyEnabled & ~cpuIrqMask;
    assign waitWakeReq = timerIrq & ~haltMode;

    // Read data, one cycle after the strobe
    logic [7:0] rdNext;
    always_comb begin
        case (regAddr)
            `CCT_IDX_CTRL_ONE: rdNext = ctrlOne_q;
            `CCT_IDX_CTRL_TWO: rdNext = ctrlTwo_q;
            `CCT_IDX_STATUS:   rdNext = {flags_q, 3'b000};
            `CCT_IDX_CAP_A_HI: rdNext = capA_q[15:8];
            `CCT_IDX_CAP_A_LO: rdNext = capA_q[7:0];
            `CCT_IDX_CMP_A_HI: rdNext = cmpA_q[15:8];
            `CCT_IDX_CMP_A_LO: rdNext = cmpA_q[7:0];
            `CCT_IDX_CNT_HI:   rdNext = count_q[15:8];
            `CCT_IDX_CNT_LO:   rdNext = count_q[7:0];
            `CCT_IDX_ALT_HI:   rdNext = count_q[15:8];
            `CCT_IDX_ALT_LO:   rdNext = count_q[7:0];
            `CCT_IDX_CAP_B_HI: rdNext = capB_q[15:8];
            `CCT_IDX_CAP_B_LO: rdNext = capB_q[7:0];
            `CCT_IDX_CMP_B_HI: rdNext = cmpB_q[15:8];
            `CCT_IDX_CMP_B_LO: rdNext = cmpB_q[7:0];
            default:           rdNext = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= regRead ? rdNext : 8'h00;
        end
    end

    assign regRdData = rdData_q;

endmodule

// ---- verif/cct_pins.sv ----
// Far side of the timer: capture pin sources and external clock source.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/100ps
module cct_pins (
    input  wire logic clock,
    output logic      capturePinA,
    output logic      capturePinB,
    output logic      extClockPin
);
    initial begin
        capturePinA = 1'b0;
        capturePinB = 1'b0;
        extClockPin = 1'b0;
    end
    task automatic setA(input logic v);
        @(posedge clock);
        capturePinA <= v;
    endtask
    task automatic setB(input logic v);
        @(posedge clock);
        capturePinB <= v;
    endtask
    // Clock runs only while asked, three cycles per phase
    task automatic extPulses(input int n);
        repeat (n) begin
            repeat (3) @(posedge clock);
            extClockPin <= 1'b1;
            repeat (3) @(posedge clock);
            extClockPin <= 1'b0;
        end
    endtask
endmodule

// ---- verif/cct_props.sv ----
// Concurrent checks on the ports of the capture/compare timer.
// Assumes one clock domain and the synchronous reset srst.
`timescale 1ns/100ps
`include "cct_consts.svh"
module cct_props (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic       haltMode,
    input wire logic       cpuIrqMask,
    input wire logic       comparePinA,
    input wire logic       comparePinAEn,
    input wire logic       comparePinB,
    input wire logic       comparePinBEn,
    input wire logic       timerIrq,
    input wire logic       waitWakeReq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Write of control one with every interrupt enable clear
    sequence ctrlOneOff;
        regWrite && regAddr == `CCT_IDX_CTRL_ONE && regWrData[7:5] == 3'b000;
    endsequence
    // Write that forces level a onto an enabled pin a
    sequence forceAOn;
        regWrite && regAddr == `CCT_IDX_CTRL_ONE && regWrData[3]
            && comparePinAEn;
    endsequence
    sequence ctrlTwoWr;
        regWrite && regAddr == `CCT_IDX_CTRL_TWO;
    endsequence

    irq_masked_a: assert property (cpuIrqMask |-> !timerIrq)
        else $error("timer irq raised while masked");
    wait_wake_a: assert property (
        1'b1 |-> waitWakeReq == (timerIrq && !haltMode))
        else $error("wait wake request differs from irq");
    irq_off_a: assert property (ctrlOneOff |=> !timerIrq)
        else $error("irq with all enables clear");
    route_first_a: assert property (
        ctrlTwoWr |=> comparePinAEn == $past(regWrData[7]))
        else $error("pin a enable not taken from control two");
    route_second_a: assert property (
        ctrlTwoWr |=> comparePinBEn == $past(regWrData[6]))
        else $error("pin b enable not taken from control two");
    status_low_a: assert property (
        regRead && regAddr == `CCT_IDX_STATUS
            |=> regRdData[2:0] == 3'b000)
        else $error("status low bits not zero");
    force_level_a: assert property (
        forceAOn |=> ##1 comparePinA == $past(regWrData[0], 2))
        else $error("forced level a not on pin a");
    halt_freeze_a: assert property (
        haltMode && $past(haltMode) && !$past(regWrite)
            && !$past(regWrite, 2)
            |-> $stable(comparePinA) && $stable(comparePinB))
        else $error("compare pins moved in halt");
endmodule

bind cct_timer cct_props chk (.clock, .srst, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .haltMode, .cpuIrqMask, .comparePinA,
    .comparePinAEn, .comparePinB, .comparePinBEn, .timerIrq, .waitWakeReq);

// ---- verif/tb_top.sv ----
// Self-checking bench for the capture/compare timer.
// Assumes the pin model and the bound checker are compiled with it.
`timescale 1ns/100ps
`include "cct_consts.svh"
module tb_top;
    typedef struct {
        logic [7:0] c2;
        int         n;
        logic [7:0] d;
    } cct_row_s;
    logic       clock;
    logic       srst;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regRdData;
    logic       haltMode;
    logic       wakeByIrq;
    logic       cpuIrqMask;
    logic       capturePinA;
    logic       capturePinB;
    logic       extClockPin;
    logic       comparePinA;
    logic       comparePinAEn;
    logic       comparePinB;
    logic       comparePinBEn;
    logic       timerIrq;
    logic       waitWakeReq;
    int         errors = 0;
    int         checked = 0;
    int         cycles = 0;
    logic [7:0] a;
    logic [7:0] b;
    // Clock select, external edges, counter advance over 64 cycles
    cct_row_s   rows [5] = '{'{8'h00, 0, 8'h10}, '{8'h04, 0, 8'h20},
        '{8'h08, 0, 8'h08}, '{8'h0D, 5, 8'h05}, '{8'h0C, 5, 8'h05}};
    logic [3:0] rstAd [6] = '{`CCT_IDX_CNT_HI, `CCT_IDX_CNT_LO,
        `CCT_IDX_CTRL_ONE, `CCT_IDX_CTRL_TWO, `CCT_IDX_CMP_A_HI,
        `CCT_IDX_STATUS};
    logic [7:0] rstVal [6] = '{8'hFF, 8'hFC, 8'h00, 8'h00, 8'h80, 8'h00};

    cct_timer #(.HAS_EXT_CLOCK(1'b1)) DUT (.clock, .srst, .regAddr,
        .regWrData, .regWrite, .regRead, .regRdData, .haltMode, .wakeByIrq,
        .cpuIrqMask, .capturePinA, .capturePinB, .extClockPin, .comparePinA,
        .comparePinAEn, .comparePinB, .comparePinBEn, .timerIrq,
        .waitWakeReq);
    cct_pins pinModel (.clock, .capturePinA, .capturePinB, .extClockPin);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic results;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chkByte(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkBit(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clock);
        regWrite  <= 1'b1;
        regAddr   <= ad;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [7:0] v);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= ad;
        @(posedge clock);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            results();
        end
    end

    initial begin
        srst = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        haltMode = 1'b0;
        wakeByIrq = 1'b0;
        cpuIrqMask = 1'b0;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        foreach (rows[i]) begin
            wr(`CCT_IDX_CTRL_TWO, rows[i].c2);
            rd(`CCT_IDX_CNT_LO, a);
            pinModel.extPulses(rows[i].n);
            repeat (62 - 6 * rows[i].n) @(posedge clock);
            rd(`CCT_IDX_CNT_LO, b);
            chkByte(8'(b - a), rows[i].d);
            $display("row %0d done", i);
        end
        // Second reset taken inside halt keeps the reset count
        @(posedge clock);
        haltMode <= 1'b1;
        srst <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        foreach (rstAd[i]) begin
            rd(rstAd[i], b);
            chkByte(b, rstVal[i]);
        end
        @(posedge clock);
        haltMode <= 1'b0;
        step(40);
        chkBit(timerIrq, 1'b0);
        wr(`CCT_IDX_CTRL_ONE, 8'h20);
        step(1);
        chkBit(timerIrq, 1'b1);
        rd(`CCT_IDX_STATUS, b);
        chkByte(b, 8'h20);
        @(posedge clock);
        cpuIrqMask <= 1'b1;
        step(1);
        chkBit(timerIrq, 1'b0);
        rd(`CCT_IDX_CNT_LO, a);
        rd(`CCT_IDX_STATUS, b);
        chkByte(b, 8'h00);
        $display("reset and overflow done");
        @(posedge clock);
        cpuIrqMask <= 1'b0;
        wr(`CCT_IDX_CTRL_ONE, 8'h82);
        @(posedge clock);
        haltMode <= 1'b1;
        step(3);
        rd(`CCT_IDX_CNT_LO, a);
        step(20);
        rd(`CCT_IDX_CNT_LO, b);
        chkByte(b, a);
        pinModel.setA(1'b1);
        step(8);
        rd(`CCT_IDX_STATUS, b);
        chkByte(b, 8'h00);
        chkBit(waitWakeReq, 1'b0);
        @(posedge clock);
        haltMode <= 1'b0;
        wakeByIrq <= 1'b1;
        @(posedge clock);
        wakeByIrq <= 1'b0;
        step(4);
        chkBit(waitWakeReq, 1'b1);
        rd(`CCT_IDX_STATUS, b);
        chkByte(b, 8'h80);
        rd(`CCT_IDX_CAP_A_LO, b);
        chkByte(b, a);
        pinModel.setB(1'b1);
        step(8);
        rd(`CCT_IDX_STATUS, b);
        chkByte(b, 8'h00);
        pinModel.setB(1'b0);
        step(8);
        rd(`CCT_IDX_STATUS, b);
        chkByte(b, 8'h10);
        $display("halt and capture done");
        wr(`CCT_IDX_CTRL_TWO, 8'hC0);
        wr(`CCT_IDX_CTRL_ONE, 8'h1D);
        step(3);
        chkBit(comparePinA, 1'b1);
        chkBit(comparePinB, 1'b1);
        chkBit(comparePinBEn, 1'b1);
        chkBit(comparePinAEn, 1'b1);
        wr(`CCT_IDX_CTRL_ONE, 8'h18);
        step(3);
        chkBit(comparePinA, 1'b0);
        chkBit(comparePinB, 1'b0);
        $display("forced pins done");
        wr(4'h0, 8'hFF);
        rd(4'h0, b);
        chkByte(b, 8'h00);
        wr(`CCT_IDX_STATUS, 8'hFF);
        rd(`CCT_IDX_STATUS, b);
        chkByte(b, 8'h10);
        $display("refused access done");
        results();
    end
endmodule
